// >>> common/asram_pkg.sv
// types shared by the static memory host port
package asram_pkg;
  // ============================================================
  // controller states
  typedef enum logic [2:0] {
    ASRAM_IDLE    = 3'b000,
    ASRAM_READ    = 3'b001,
    ASRAM_WRITE   = 3'b010,
    ASRAM_HOLD    = 3'b011,
    ASRAM_RELEASE = 3'b100
  } asram_state_t;

  typedef logic [18:0] asram_addr_t;
  typedef logic [7:0]  asram_data_t;
endpackage : asram_pkg

// >>> common/asram_regs.svh
// timing constants and field layout for the static memory host port
`ifndef ASRAM_REGS_SVH
`define ASRAM_REGS_SVH

// ============================================================
// geometry
`define ASRAM_ADDR_W 19
`define ASRAM_DATA_W 8

// ============================================================
// timing figures in ns (faster grade) and the clock period in ns
`define ASRAM_CLK_PERIOD_NS        4
`define ASRAM_READ_CYCLE_NS        45
`define ASRAM_ADDR_TO_DATA_NS      45
`define ASRAM_ADDR_SETUP_TO_END_NS 35
`define ASRAM_DATA_SETUP_NS        25
`define ASRAM_STROBE_RELEASE_NS    18
`define ASRAM_DISABLE_RELEASE_NS   18
`define ASRAM_STANDBY_ENTRY_NS     45

// least times round up, to whole clock cycles
`define ASRAM_CYC_UP(ns) \
  (((ns) + `ASRAM_CLK_PERIOD_NS - 1) / `ASRAM_CLK_PERIOD_NS)
`define ASRAM_READ_CYC    `ASRAM_CYC_UP(`ASRAM_ADDR_TO_DATA_NS)
`define ASRAM_WRITE_CYC \
  `ASRAM_CYC_UP(`ASRAM_ADDR_SETUP_TO_END_NS + `ASRAM_STROBE_RELEASE_NS)
`define ASRAM_RELEASE_CYC `ASRAM_CYC_UP(`ASRAM_DISABLE_RELEASE_NS)
`define ASRAM_STANDBY_CYC `ASRAM_CYC_UP(`ASRAM_STANDBY_ENTRY_NS)

`endif

// >>> core/asram_host.sv
// host controller that drives an asynchronous byte-wide static memory
// Function
// - write starts when select and strobe low
// - either select or strobe rising ends write
// - hold write data around ending edge
// - read keeps strobe high, select/enable low
// - address valid before select falls; host drives address on the same edge as select
// - strobe low covers release plus setup
// - address stable before write ending edge
`timescale 1ns/1ps
`default_nettype none
`include "asram_regs.svh"
module asram_host (
  input  wire logic                clk_i,
  input  wire logic                rst_n_i,
  // user request side
  input  wire logic                req_valid_i,
  output logic                     req_ready_o,
  input  wire logic                req_write_i,
  input  wire asram_pkg::asram_addr_t req_addr_i,
  input  wire asram_pkg::asram_data_t req_wdata_i,
  output logic                     rsp_valid_o,
  output asram_pkg::asram_data_t   rsp_rdata_o,
  output logic                     standby_o,
  // memory pins
  output logic                     mem_select_n_o,
  output logic                     mem_strobe_n_o,
  output logic                     mem_out_en_n_o,
  output asram_pkg::asram_addr_t   mem_addr_o,
  input  wire asram_pkg::asram_data_t mem_data_i,
  output asram_pkg::asram_data_t   mem_data_o,
  output logic                     mem_data_oe_o
);
  import asram_pkg::*;

  asram_state_t state_q, state_d;
  asram_addr_t  addr_q, addr_d;
  asram_data_t  wdata_q, wdata_d;
  asram_data_t  rdata_q, rdata_d;
  logic         sel_n_q, sel_n_d;
  logic         stb_n_q, stb_n_d;
  logic         oe_n_q, oe_n_d;
  logic         doe_q, doe_d;
  logic         rsp_q, rsp_d;
  logic         sby_q, sby_d;
  logic         load;
  logic [5:0]   load_val;
  logic         done;

  // converts a cycle count into the counter's width; zero is not allowed
  function automatic logic [5:0] cyc6(input int n);
    cyc6 = (n < 1) ? 6'h01 : 6'(n);
  endfunction : cyc6

  // ============================================================
  // phase timer
  asram_wait_cnt u_wait (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .load_i  (load),
    .value_i (load_val),
    .done_o  (done)
  );

  // ============================================================
  // access timing, in clock edges after the accept edge
  // a timer loaded with n ends its phase n + 1 cycles later, since
  // done shows only once the count is back at zero; each phase is
  // therefore one cycle longer than its bare rounded-up figure,
  // which costs a little throughput but leaves margin on every
  // minimum time of the memory
  // read:
  //   edge 0   select and output enable fall with the address
  //   edge 13  byte captured, select and enable rise, response
  //   edge 19  bus release wait over, ready for the next request
  // write:
  //   edge 0   select and strobe fall, data and address driven
  //   edge 1..15 strobe low, address and data held still
  //   edge 15  strobe rises alone and ends the write
  //   edge 16  select rises, data released, response, ready
  // the write ends by the strobe; select is only the frame around it
  // the host stops driving one edge after the ending edge, so data
  // hold is met without relying on any delay of the memory
  // output enable stays high for the whole write, so the memory is
  // never driving when the host turns its own drivers on
  // standby is only an estimate, since the memory has no status pin;
  // its timer restarts whenever the sequencer goes back to idle

  // ============================================================
  // access sequencer
  always_comb begin
    state_d  = state_q;
    addr_d   = addr_q;
    wdata_d  = wdata_q;
    rdata_d  = rdata_q;
    sel_n_d  = sel_n_q;
    stb_n_d  = stb_n_q;
    oe_n_d   = oe_n_q;
    doe_d    = doe_q;
    rsp_d    = 1'b0;
    sby_d    = sby_q;
    load     = 1'b0;
    load_val = 6'h00;
    unique case (state_q)
      ASRAM_IDLE: begin
        if (req_valid_i) begin
          // address goes out with select, never after it
          addr_d  = req_addr_i;
          sel_n_d = 1'b0;
          sby_d   = 1'b0;
          load    = 1'b1;
          if (req_write_i) begin
            // select and strobe fall together, enable stays high,
            // so the memory is never driving when we start to
            wdata_d  = req_wdata_i;
            stb_n_d  = 1'b0;
            oe_n_d   = 1'b1;
            doe_d    = 1'b1;
            // strobe low spans release plus setup and address setup
            load_val = cyc6(`ASRAM_WRITE_CYC);
            state_d  = ASRAM_WRITE;
          end else begin
            // strobe held high during a read
            stb_n_d  = 1'b1;
            oe_n_d   = 1'b0;
            doe_d    = 1'b0;
            load_val = cyc6(`ASRAM_READ_CYC);
            state_d  = ASRAM_READ;
          end
        end
      end
      ASRAM_READ: begin
        if (done) begin
          rdata_d  = mem_data_i;
          rsp_d    = 1'b1;
          sel_n_d  = 1'b1;
          oe_n_d   = 1'b1;
          load     = 1'b1;
          // wait out the memory's bus release before anyone drives
          load_val = cyc6(`ASRAM_RELEASE_CYC);
          state_d  = ASRAM_RELEASE;
        end
      end
      ASRAM_WRITE: begin
        if (done) begin
          // the strobe rising alone ends the write
          stb_n_d = 1'b1;
          state_d = ASRAM_HOLD;
        end
      end
      ASRAM_HOLD: begin
        // data and address held one cycle past the ending edge
        sel_n_d  = 1'b1;
        doe_d    = 1'b0;
        rsp_d    = 1'b1;
        load     = 1'b1;
        load_val = cyc6(`ASRAM_STANDBY_CYC);
        state_d  = ASRAM_IDLE;
      end
      ASRAM_RELEASE: begin
        if (done) begin
          load     = 1'b1;
          load_val = cyc6(`ASRAM_STANDBY_CYC);
          state_d  = ASRAM_IDLE;
        end
      end
      default: begin
        state_d = ASRAM_IDLE;
      end
    endcase
    // standby is reported once the power-down delay has passed
    if (state_q == ASRAM_IDLE && !req_valid_i && done && sel_n_q) begin
      sby_d = 1'b1;
    end
  end

  // ============================================================
  // state registers; pins idle deselected with the bus released
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q <= ASRAM_IDLE;
      addr_q  <= 19'h00000;
      wdata_q <= 8'h00;
      rdata_q <= 8'h00;
      sel_n_q <= 1'b1;
      stb_n_q <= 1'b1;
      oe_n_q  <= 1'b1;
      doe_q   <= 1'b0;
      rsp_q   <= 1'b0;
      sby_q   <= 1'b1;
    end else begin
      state_q <= state_d;
      addr_q  <= addr_d;
      wdata_q <= wdata_d;
      rdata_q <= rdata_d;
      sel_n_q <= sel_n_d;
      stb_n_q <= stb_n_d;
      oe_n_q  <= oe_n_d;
      doe_q   <= doe_d;
      rsp_q   <= rsp_d;
      sby_q   <= sby_d;
    end
  end

  // ============================================================
  // outputs
  assign req_ready_o    = (state_q == ASRAM_IDLE);
  assign rsp_valid_o    = rsp_q;
  assign rsp_rdata_o    = rdata_q;
  assign standby_o      = sby_q;
  assign mem_select_n_o = sel_n_q;
  assign mem_strobe_n_o = stb_n_q;
  assign mem_out_en_n_o = oe_n_q;
  assign mem_addr_o     = addr_q;
  assign mem_data_o     = wdata_q;
  assign mem_data_oe_o  = doe_q; // only while enable is high
endmodule : asram_host
`default_nettype wire

// >>> core/asram_wait_cnt.sv
// down counter that times each phase of a memory access
`timescale 1ns/1ps
`default_nettype none
module asram_wait_cnt (
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       load_i,
  input  wire logic [5:0] value_i,
  output logic            done_o
);
  logic [5:0] cnt_q;
  logic [5:0] cnt_d;

  // ============================================================
  // next count: load wins, otherwise step down to zero
  always_comb begin
    cnt_d = cnt_q;
    if (load_i) begin
      cnt_d = value_i;
    end else if (cnt_q != 6'h00) begin
      cnt_d = cnt_q - 6'h01;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_q <= 6'h00;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  // done looks at the count alone: the sequencer raises load from done,
  // so gating done with load would close a zero-delay loop
  assign done_o = (cnt_q == 6'h00);
endmodule : asram_wait_cnt
`default_nettype wire

// >>> tb/asram_host_chk.sv
// pin protocol assertions for the static memory host port
`timescale 1ns/1ps
`default_nettype none
module asram_host_chk (
  input wire logic                   clk_i,
  input wire logic                   rst_n_i,
  input wire logic                   req_valid_i,
  input wire logic                   req_ready_o,
  input wire logic                   req_write_i,
  input wire logic                   rsp_valid_o,
  input wire logic                   standby_o,
  input wire logic                   mem_select_n_o,
  input wire logic                   mem_strobe_n_o,
  input wire logic                   mem_out_en_n_o,
  input wire asram_pkg::asram_addr_t mem_addr_o,
  input wire asram_pkg::asram_data_t mem_data_o,
  input wire logic                   mem_data_oe_o
);
  import asram_pkg::*;
  // ============================================================
  // one clock domain, so clock and reset are given once
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  a_read_strobe_hi: assert property (
    (!mem_select_n_o && !mem_out_en_n_o) |-> mem_strobe_n_o)
    else $error("strobe low in read");
  a_write_start: assert property (
    $fell(mem_strobe_n_o) |-> (!mem_select_n_o && mem_data_oe_o))
    else $error("bad write start");
  // the timer runs the strobe phase one cycle past its count,
  // so the strobe is seen low on fifteen edges
  a_strobe_width: assert property (
    $fell(mem_strobe_n_o) |->
      !mem_strobe_n_o[*7] ##1 !mem_strobe_n_o[*8] ##1 mem_strobe_n_o)
    else $error("strobe width wrong");
  a_write_held: assert property (
    (!mem_strobe_n_o && $past(!mem_strobe_n_o)) |->
      ($stable(mem_addr_o) && $stable(mem_data_o)))
    else $error("addr or data moved in write");
  a_write_end: assert property (
    $rose(mem_strobe_n_o) |-> (!mem_select_n_o && mem_data_oe_o)
      ##1 (mem_select_n_o && !mem_data_oe_o))
    else $error("bad write end");
  a_addr_sel_stable: assert property (
    (!mem_select_n_o && $past(!mem_select_n_o)) |-> $stable(mem_addr_o))
    else $error("addr moved");
  // response register adds one edge after the capture edge
  a_read_lat: assert property (
    (req_valid_i && req_ready_o && !req_write_i) |->
      ##1 (!mem_select_n_o && !mem_out_en_n_o) ##13 rsp_valid_o)
    else $error("read timing wrong");
  a_write_lat: assert property (
    (req_valid_i && req_ready_o && req_write_i) |->
      ##1 !mem_strobe_n_o ##16 rsp_valid_o)
    else $error("write timing wrong");
  a_no_clash: assert property (
    !mem_out_en_n_o |-> !mem_data_oe_o)
    else $error("bus clash");
  a_standby_desel: assert property (
    standby_o |-> mem_select_n_o)
    else $error("standby while selected");
  c_read: cover property (req_valid_i && req_ready_o && !req_write_i);
  c_write: cover property ($rose(mem_strobe_n_o));
  c_standby: cover property ($rose(standby_o));
endmodule : asram_host_chk
bind asram_host asram_host_chk u_chk (.*);
`default_nettype wire

// >>> tb/asram_mem_model.sv
// behavioural byte-wide static memory facing the host port
`timescale 1ns/1ps
`default_nettype none
module asram_mem_model #(parameter int ACC_NS = 44) (
  input  wire logic                   sel_n_i,
  input  wire logic                   we_n_i,
  input  wire logic                   oe_n_i,
  input  wire asram_pkg::asram_addr_t addr_i,
  input  wire asram_pkg::asram_data_t dq_i,
  output asram_pkg::asram_data_t      dq_o,
  output logic                        dq_oe_o
);
  import asram_pkg::*;
  asram_data_t mem [0:524287];
  asram_data_t last_q = 8'h00;
  logic        rd_req;
  logic        rd_dly;
  logic        stby;
  // ============================================================
  // drives only when selected, enabled and not writing
  assign rd_req = !sel_n_i && !oe_n_i && we_n_i;
  // slow to drive but releases at once
  assign #(ACC_NS) rd_dly = rd_req;
  assign dq_oe_o = rd_req && rd_dly;
  // a released bus shows the inverse of its last value, never a kind one
  assign dq_o = dq_oe_o ? mem[addr_i] : ~last_q;
  assign #(45) stby = sel_n_i;
  // a write lands on whichever of select or strobe rises first; any
  // other edge, such as a read letting go of the bus, remembers the
  // byte last seen so one process alone owns last_q
  always @(posedge we_n_i or posedge sel_n_i or negedge dq_oe_o) begin
    if (!sel_n_i || !we_n_i) begin
      mem[addr_i] = dq_i;
      last_q = dq_i;
    end else begin
      last_q = mem[addr_i];
    end
  end
endmodule : asram_mem_model
`default_nettype wire

// >>> tb/tb_async_sram_access_port.sv
// self-checking bench for the static memory host port
`timescale 1ns/1ps
`default_nettype none
`include "asram_regs.svh"
module tb_async_sram_access_port;
  import asram_pkg::*;
  logic clk_i, rst_n_i, req_valid_i, req_write_i, req_ready_o, rsp_valid_o;
  logic standby_o, mem_select_n_o, mem_strobe_n_o, mem_out_en_n_o;
  logic mem_data_oe_o, m_oe;
  asram_addr_t req_addr_i, mem_addr_o, a;
  asram_data_t req_wdata_i, rsp_rdata_o, mem_data_o, mem_data_i, m_dq, d, q;
  asram_data_t ref_q [asram_addr_t];
  int errors, tests_run, seed, lat;
  asram_host dut (
    .clk_i          (clk_i),
    .rst_n_i        (rst_n_i),
    .req_valid_i    (req_valid_i),
    .req_ready_o    (req_ready_o),
    .req_write_i    (req_write_i),
    .req_addr_i     (req_addr_i),
    .req_wdata_i    (req_wdata_i),
    .rsp_valid_o    (rsp_valid_o),
    .rsp_rdata_o    (rsp_rdata_o),
    .standby_o      (standby_o),
    .mem_select_n_o (mem_select_n_o),
    .mem_strobe_n_o (mem_strobe_n_o),
    .mem_out_en_n_o (mem_out_en_n_o),
    .mem_addr_o     (mem_addr_o),
    .mem_data_i     (mem_data_i),
    .mem_data_o     (mem_data_o),
    .mem_data_oe_o  (mem_data_oe_o)
  );
  asram_mem_model mem (.sel_n_i(mem_select_n_o), .we_n_i(mem_strobe_n_o),
    .oe_n_i(mem_out_en_n_o), .addr_i(mem_addr_o), .dq_i(mem_data_i),
    .dq_o(m_dq), .dq_oe_o(m_oe));
  // a clash on the bus reads as unknown so it cannot pass
  assign mem_data_i = (mem_data_oe_o && m_oe) ? 8'hxx
                    : (mem_data_oe_o ? mem_data_o : m_dq);
  // ============================================================
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  task automatic chk_byte(input string n, input asram_data_t e,
                          input asram_data_t g);
    tests_run++;
    if (g !== e) begin
      errors++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : chk_byte
  task automatic chk_int(input string n, input int e, input int g);
    tests_run++;
    if (g != e) begin
      errors++;
      $display("Error %s expected %0d seen %0d", n, e, g);
    end
  endtask : chk_int
  // negedges from the accept edge to the response: each timed phase
  // runs one cycle past its count, the response register adds one,
  // and a write holds its data one more cycle past the strobe
  function automatic int exp_lat(input logic w);
    exp_lat = w ? `ASRAM_WRITE_CYC + 3 : `ASRAM_READ_CYC + 2;
  endfunction : exp_lat
  // holds the request until the accept edge, then counts to the answer
  task automatic op(input logic w, input asram_addr_t ad,
                    input asram_data_t dt);
    int n;
    @(posedge clk_i);
    req_valid_i <= 1'b1;
    req_write_i <= w;
    req_addr_i <= ad;
    req_wdata_i <= dt;
    n = 0;
    do begin
      @(negedge clk_i);
      n++;
    end while (req_ready_o !== 1'b1 && n < 100);
    @(posedge clk_i);
    req_valid_i <= 1'b0;
    lat = 0;
    do begin
      @(negedge clk_i);
      lat++;
    end while (rsp_valid_o !== 1'b1 && lat < 100);
    q = rsp_rdata_o;
  endtask : op
  task automatic wr_rd(input asram_addr_t ad, input asram_data_t dt);
    op(1'b1, ad, dt);
    chk_int("write latency", exp_lat(1'b1), lat);
    ref_q[ad] = dt;
    op(1'b0, ad, 8'h00);
    chk_int("read latency", exp_lat(1'b0), lat);
    chk_byte("read data", ref_q[ad], q);
  endtask : wr_rd
  task automatic end_sim();
    $display("checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : end_sim
  // about 1050 cycles of traffic expected, so this margin is generous
  initial begin
    #20000;
    errors++;
    end_sim();
  end
  initial begin
    seed = 89318;
    errors = 0;
    tests_run = 0;
    rst_n_i = 1'b0;
    req_valid_i = 1'b0;
    req_write_i = 1'b0;
    req_addr_i = '0;
    req_wdata_i = '0;
    repeat (20) @(posedge clk_i);
    chk_byte("select idle", 8'h01, {7'h00, mem_select_n_o});
    rst_n_i <= 1'b1;
    wr_rd(19'h00000, 8'h00);
    wr_rd(19'h7ffff, 8'hff);
    $display("test corners done");
    repeat (24) begin
      a = asram_addr_t'($random(seed));
      d = asram_data_t'($random(seed));
      wr_rd(a, d);
    end
    $display("test random done");
    op(1'b0, 19'h00000, 8'h00);
    chk_byte("reread", ref_q[19'h00000], q);
    chk_int("reread latency", exp_lat(1'b0), lat);
    repeat (20) @(posedge clk_i);
    chk_byte("standby", 8'h01, {7'h00, standby_o});
    chk_byte("memory standby", 8'h01, {7'h00, mem.stby});
    $display("test standby done");
    end_sim();
  end
endmodule : tb_async_sram_access_port
`default_nettype wire
